// [rtl/rh_hub_status.sv]
// Root hub global status, power control and port status registers
// What this block does
// - Writing 1 to bit 31 clears remote wakeup enable unless bit 15 is also 1; 0 leaves it.
// - Overcurrent indicator change sets bit 17; write 1 clears it.
// - Bits 16 and 0 of the hub register always read zero.
// - Global mode: writing 1 to bit 16 powers all ports on unless bit 0 is also 1.
// - Per-port mode: bit 16 powers on only ports with mask clear, unless bit 0 is also 1.
// - Global mode: writing 1 to bit 0 powers all ports off.
// - Per-port mode: bit 0 powers off only ports with mask clear.
// - With wakeup enabled, connect change resumes suspended bus and interrupts.
// - Writing 1 to bit 15 sets remote wakeup enable; 0 leaves it.
// - Bit 1 shows global overcurrent; zero when reported per port.
// - One port status register per downstream port.
// - Port registers read at 15h/16h, written at 95h/96h.
// - Port status writes during a transaction wait until it completes.
// - Port change bits 20..16, low speed 9, power 8, reset zero.
// - Per-port mode, mask set: port power follows only per-port commands.
// - Hub register read at 14h, written at 94h.
`timescale 1ns/1ps
module rh_hub_status
  import rh_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
)(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  // Host register port
  input  wire logic              acc_in,
  input  wire logic [7:0]        code_in,
  input  wire logic [31:0]       wdata_in,
  output logic [31:0]            rdata_out,
  // Configuration
  input  wire logic              power_switch_scheme_in,
  input  wire logic [PORTS-1:0]  per_port_power_mask_in,
  input  wire logic              per_port_oc_in,
  input  wire logic              bus_suspend_req_in,
  input  wire logic              resume_done_in,
  // Pins and port events
  input  wire logic              overcurrent_pin_in,
  input  wire port_event_t [PORTS-1:0] port_ev_in,
  // Outputs
  output logic [PORTS-1:0]       port_power_out,
  output bus_state_t             bus_state_out,
  output logic                   resume_seen_interrupt_out
);
  logic       oc_meta_ff;
  logic       oc_sync_ff;
  logic       oc_ff;
  logic       oc_chg_ff;
  logic       wake_ff;
  logic [31:0] rdata_ff;
  bus_state_t state_ff;
  logic       irq_ff;
  logic [PORTS-1:0] pwr_q_ff;
  logic [PORTS-1:0][31:0] pstat;
  logic       hub_wr;
  logic       gon;
  logic       goff;
  logic       any_conn;
  logic       oc_now;

  assign hub_wr = acc_in && code_in == CODE_HUB_WR;
  assign gon    = hub_wr && wdata_in[HUB_SET_PWR_BIT];
  assign goff   = hub_wr && wdata_in[HUB_CLR_PWR_BIT];
  assign oc_now = oc_sync_ff && !per_port_oc_in;

  // Synchronise overcurrent pin
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      oc_meta_ff <= 1'b0;
      oc_sync_ff <= 1'b0;
      oc_ff      <= 1'b0;
    end else begin
      oc_meta_ff <= overcurrent_pin_in;
      oc_sync_ff <= oc_meta_ff;
      oc_ff      <= oc_now;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) oc_chg_ff <= 1'b0;
    else if (oc_now != oc_ff) oc_chg_ff <= 1'b1;
    else if (hub_wr && wdata_in[HUB_OC_CHG_BIT]) oc_chg_ff <= 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) wake_ff <= 1'b0;
    else if (hub_wr && wdata_in[HUB_WAKE_EN_BIT]) wake_ff <= 1'b1;
    else if (hub_wr && wdata_in[HUB_CLR_WAKE_BIT]) wake_ff <= 1'b0;
  end

  // Any port reporting a connect change
  always_comb begin
    any_conn = 1'b0;
    for (int i = 0; i < PORTS; i++)
      any_conn = any_conn | port_ev_in[i].attach_change_event;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_ff <= ST_OPER;
      irq_ff   <= 1'b0;
    end else begin
      irq_ff <= 1'b0;
      case (state_ff)
        ST_OPER:    if (bus_suspend_req_in) state_ff <= ST_SUSPEND;
        ST_SUSPEND: if (wake_ff && any_conn) begin
          state_ff <= ST_RESUME;
          irq_ff   <= 1'b1;
        end
        ST_RESUME:  if (resume_done_in) state_ff <= ST_OPER;
        default:    state_ff <= ST_OPER;
      endcase
    end
  end

  for (genvar g = 0; g < PORTS; g++) begin : g_port
    logic ctl;
    logic wr;
    assign ctl = !power_switch_scheme_in || !per_port_power_mask_in[g];
    assign wr  = acc_in && code_in == CODE_PORT1_WR + 8'(g);
    rh_port_status u_port (
      .clk_in      (clk_in),
      .srst_in     (srst_in),
      .wr_in       (wr),
      .wdata_in    (wdata_in),
      .gpwr_on_in  (gon && ctl),
      .gpwr_off_in (goff && ctl),
      .ev_in       (port_ev_in[g]),
      .status_out  (pstat[g])
    );
  end

  // Read mux and registered outputs
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_ff <= RESET_WORD;
      pwr_q_ff <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) pwr_q_ff[i] <= pstat[i][PORT_PWR_BIT];
      rdata_ff <= RESET_WORD;
      // indicator masked when reported per port
      if (acc_in && code_in == CODE_HUB_RD)
        rdata_ff <= {14'h0000, oc_chg_ff, 1'b0, wake_ff, 13'h0000,
                     oc_ff && !per_port_oc_in, 1'b0};
      for (int i = 0; i < PORTS; i++)
        if (acc_in && code_in == CODE_PORT1_RD + 8'(i)) rdata_ff <= pstat[i];
    end
  end

  assign rdata_out                 = rdata_ff;
  assign port_power_out            = pwr_q_ff;
  assign bus_state_out             = state_ff;
  assign resume_seen_interrupt_out = irq_ff;

  property p_oc_chg;
    @(posedge clk_in) disable iff (srst_in)
      (oc_now != oc_ff) |=> oc_chg_ff;
  endproperty
  a_oc_chg: assert property (p_oc_chg) else $error("oc change lost");

  property p_wake_set;
    @(posedge clk_in) disable iff (srst_in)
      (hub_wr && wdata_in[HUB_WAKE_EN_BIT]) |=> wake_ff;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake not set");

  property p_wake_clr;
    @(posedge clk_in) disable iff (srst_in)
      (hub_wr && wdata_in[HUB_CLR_WAKE_BIT] && !wdata_in[HUB_WAKE_EN_BIT])
      |=> !wake_ff;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake not clr");

  sequence s_wake_event;
    state_ff == ST_SUSPEND && wake_ff && any_conn;
  endsequence
  property p_resume;
    @(posedge clk_in) disable iff (srst_in)
      s_wake_event |=> (state_ff == ST_RESUME && irq_ff);
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");

  property p_no_resume;
    @(posedge clk_in) disable iff (srst_in)
      (state_ff == ST_SUSPEND && !wake_ff) |=> !irq_ff;
  endproperty
  a_no_resume: assert property (p_no_resume) else $error("bad resume");

  property p_hub_rd;
    @(posedge clk_in) disable iff (srst_in)
      (acc_in && code_in == CODE_HUB_RD) |=>
        (rdata_out[HUB_SET_PWR_BIT] == 1'b0 && rdata_out[0] == 1'b0
         && rdata_out[HUB_OC_BIT] ==
            ($past(oc_ff) && !$past(per_port_oc_in)));
  endproperty
  a_hub_rd: assert property (p_hub_rd) else $error("hub read bad");

  property p_oc_per_port;
    @(posedge clk_in) disable iff (srst_in)
      (acc_in && code_in == CODE_HUB_RD && per_port_oc_in)
      |=> !rdata_out[HUB_OC_BIT];
  endproperty
  a_oc_per_port: assert property (p_oc_per_port) else $error("oci");

  property p_goff;
    @(posedge clk_in) disable iff (srst_in)
      (goff && !gon && !power_switch_scheme_in && !port_ev_in[0].busy)
      ##1 !port_ev_in[0].busy |=> !port_power_out[0];
  endproperty
  a_goff: assert property (p_goff) else $error("global off");

  // Global power on in global mode reaches every port output two cycles later
  property p_gon;
    @(posedge clk_in) disable iff (srst_in)
      (gon && !goff && !power_switch_scheme_in) |=> ##1 (&port_power_out);
  endproperty
  a_gon: assert property (p_gon) else $error("global on");
endmodule : rh_hub_status

// [rtl/rh_pkg.sv]
// Constants and types for the root hub status and power control block
package rh_pkg;
  // Access codes on the host register port
  localparam logic [7:0] CODE_HUB_RD   = 8'h14;
  localparam logic [7:0] CODE_HUB_WR   = 8'h94;
  localparam logic [7:0] CODE_PORT1_RD = 8'h15;
  localparam logic [7:0] CODE_PORT2_RD = 8'h16;
  localparam logic [7:0] CODE_PORT1_WR = 8'h95;
  localparam logic [7:0] CODE_PORT2_WR = 8'h96;
  // Hub register field positions
  localparam int HUB_CLR_WAKE_BIT  = 31;
  localparam int HUB_OC_CHG_BIT    = 17;
  localparam int HUB_SET_PWR_BIT   = 16;
  localparam int HUB_WAKE_EN_BIT   = 15;
  localparam int HUB_OC_BIT        = 1;
  localparam int HUB_CLR_PWR_BIT   = 0;
  // Port register field positions
  localparam int PORT_RST_CHG_BIT  = 20;
  localparam int PORT_OC_CHG_BIT   = 19;
  localparam int PORT_SUS_CHG_BIT  = 18;
  localparam int PORT_EN_CHG_BIT   = 17;
  localparam int PORT_CONN_CHG_BIT = 16;
  localparam int PORT_LS_BIT       = 9;
  localparam int PORT_PWR_BIT      = 8;
  // Reset value and number of ports
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int NUM_PORTS = 2;

  // Bus controller power state
  typedef enum logic [1:0] {
    ST_OPER    = 2'b00,
    ST_SUSPEND = 2'b01,
    ST_RESUME  = 2'b10
  } bus_state_t;

  // Per-port live status and events from the port logic
  typedef struct packed {
    logic low_speed_attached;
    logic reset_done;
    logic oc_changed;
    logic resume_done;
    logic enable_lost;
    logic attach_change_event;
    logic busy;
  } port_event_t;

  // One pending write held back while a port is busy
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } port_wr_t;
endpackage : rh_pkg

// [rtl/rh_port_status.sv]
// Per-port status register with deferred write handling
`timescale 1ns/1ps
module rh_port_status
  import rh_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Write from software and global power commands
  input  wire logic        wr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        gpwr_on_in,
  input  wire logic        gpwr_off_in,
  // Port events
  input  wire port_event_t ev_in,
  // Register value
  output logic [31:0]      status_out
);
  logic [4:0] chg_ff;
  logic       pwr_ff;
  logic       ls_ff;
  port_wr_t   pend_ff;
  logic       apply;
  logic [31:0] wd;

  assign apply = !ev_in.busy && (pend_ff.valid || wr_in);
  assign wd    = pend_ff.valid ? pend_ff.data : wdata_in;

  // Hold a write that arrives during a transaction or behind a held one
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pend_ff <= '0;
    end else if (wr_in && (ev_in.busy || pend_ff.valid)) begin
      pend_ff <= '{1'b1, wdata_in};
    end else if (apply) begin
      pend_ff <= '0;
    end
  end

  // change flags, set wins over clear
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chg_ff <= RESET_WORD[4:0];
    end else begin
      chg_ff <= (chg_ff & ~(apply ? wd[PORT_RST_CHG_BIT:PORT_CONN_CHG_BIT]
                                  : 5'h00))
              | {ev_in.reset_done, ev_in.oc_changed, ev_in.resume_done,
                 ev_in.enable_lost, ev_in.attach_change_event};
    end
  end

  // Port power and low speed state
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pwr_ff <= 1'b0;
      ls_ff  <= 1'b0;
    end else begin
      ls_ff <= ev_in.low_speed_attached;
      if (gpwr_off_in) pwr_ff <= 1'b0;
      else if (gpwr_on_in) pwr_ff <= 1'b1;
      else if (apply && wd[PORT_PWR_BIT]) pwr_ff <= 1'b1;
    end
  end

  assign status_out = {11'h000, chg_ff, 6'h00, ls_ff, pwr_ff, 8'h00};
endmodule : rh_port_status

// [test/rh_port_dev_model.sv]
// Downstream device model driving one root port's event lines
`timescale 1ns/1ps
module rh_port_dev_model
  import rh_pkg::*;
(
  // Clock
  input  wire logic  clk_in,
  // Scenario commands
  input  wire logic  attach_in,
  input  wire logic  busy_in,
  // Port events
  output port_event_t ev_out
);
  // Events move only after an edge; attach change follows attach_in one cycle later
  always_ff @(posedge clk_in) begin
    ev_out                     <= '0;
    ev_out.attach_change_event <= attach_in;
    ev_out.low_speed_attached  <= attach_in;
    ev_out.busy                <= busy_in;
  end
endmodule : rh_port_dev_model

// [test/rh_hub_status_tb.sv]
// Self-checking bench for the root hub status and power block
`timescale 1ns/1ps
module rh_hub_status_tb;
  import rh_pkg::*;
  logic clk_in, srst_in, acc_in, sch, ppoc, sreq, rdone, ocp;
  logic [7:0] code_in;
  logic [31:0] wdata_in, rdata_out, d;
  logic [1:0] mask, pwr, att, busy;
  port_event_t [1:0] ev;
  bus_state_t bst;
  logic rsi, seen;
  int num_errors, checks_done, cycles;
  rh_hub_status rh_hub_status_inst (.clk_in(clk_in), .srst_in(srst_in),
    .acc_in(acc_in), .code_in(code_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .power_switch_scheme_in(sch),
    .per_port_power_mask_in(mask), .per_port_oc_in(ppoc),
    .bus_suspend_req_in(sreq), .resume_done_in(rdone),
    .overcurrent_pin_in(ocp), .port_ev_in(ev), .port_power_out(pwr),
    .bus_state_out(bst), .resume_seen_interrupt_out(rsi));
  rh_port_dev_model m1 (.clk_in(clk_in), .attach_in(att[0]),
    .busy_in(busy[0]), .ev_out(ev[0]));
  rh_port_dev_model m2 (.clk_in(clk_in), .attach_in(att[1]),
    .busy_in(busy[1]), .ev_out(ev[1]));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  task stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  task wr(input logic [7:0] c, input logic [31:0] v);
    @(posedge clk_in);
    acc_in   <= 1'b1;
    code_in  <= c;
    wdata_in <= v;
    @(posedge clk_in);
    acc_in   <= 1'b0;
    wdata_in <= 32'h0;
  endtask : wr
  task rd(input logic [7:0] c);
    @(posedge clk_in);
    acc_in  <= 1'b1;
    code_in <= c;
    @(posedge clk_in);
    acc_in  <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask : rd
  // Watch a few cycles for the resume interrupt pulse
  task watch();
    seen = 1'b0;
    repeat (10) begin
      @(negedge clk_in);
      if (rsi === 1'b1) seen = 1'b1;
    end
  endtask : watch
  initial begin
    {acc_in, sch, ppoc, sreq, rdone, ocp} = '0;
    {code_in, wdata_in, mask, att, busy} = '0;
    srst_in = 1'b1;
    cyc(3);
    srst_in <= 1'b0;
    rd(8'h14); chk(32'h0, d);
    rd(8'h15); chk(32'h0, d);
    rd(8'h16); chk(32'h0, d);
    rd(8'h17); chk(32'h0, d);
    $display("test reset done");
    wr(8'h94, 32'h0000_8000); rd(8'h14); chk(32'h8000, d);
    wr(8'h94, 32'h0); rd(8'h14); chk(32'h8000, d);
    wr(8'h94, 32'h8000_0000); rd(8'h14); chk(32'h0, d);
    $display("test wake done");
    wr(8'h94, 32'h0001_0000); cyc(3); chk(2'b11, pwr);
    rd(8'h14); chk(32'h0, d);
    rd(8'h96); chk(32'h0, d);
    rd(8'h16); chk(32'h100, d);
    wr(8'h94, 32'h0000_0001); cyc(3); chk(2'b00, pwr);
    sch <= 1'b1;
    mask <= 2'b10;
    wr(8'h94, 32'h0001_0000); cyc(3); chk(2'b01, pwr);
    wr(8'h96, 32'h0000_0100); cyc(3); chk(2'b11, pwr);
    wr(8'h94, 32'h0000_0001); cyc(3); chk(2'b10, pwr);
    $display("test power done");
    mask <= 2'b11;
    busy[0] <= 1'b1;
    wr(8'h95, 32'h0000_0100); cyc(4);
    rd(8'h15); chk(32'h0, d);
    busy[0] <= 1'b0;
    cyc(4);
    rd(8'h15); chk(32'h100, d);
    $display("test defer done");
    ocp <= 1'b1;
    cyc(6);
    rd(8'h14); chk(32'h0002_0002, d);
    wr(8'h94, 32'h0002_0000); rd(8'h14); chk(32'h2, d);
    ppoc <= 1'b1;
    cyc(3);
    wr(8'h94, 32'h0002_0000); rd(8'h14); chk(32'h0, d);
    ppoc <= 1'b0;
    ocp <= 1'b0;
    cyc(6);
    wr(8'h94, 32'h0002_0000); rd(8'h14); chk(32'h0, d);
    $display("test overcurrent done");
    wr(8'h94, 32'h0000_8000);
    sreq <= 1'b1;
    cyc(1);
    sreq <= 1'b0;
    cyc(3); chk(ST_SUSPEND, bst);
    att[0] <= 1'b1;
    cyc(1);
    att[0] <= 1'b0;
    watch(); chk(1'b1, seen);
    chk(ST_RESUME, bst);
    rd(8'h15); chk(32'h1, d[16]);
    wr(8'h95, 32'h0001_0000);
    rd(8'h15); chk(32'h0, d[16]);
    rdone <= 1'b1;
    cyc(1);
    rdone <= 1'b0;
    wr(8'h94, 32'h8000_0000);
    sreq <= 1'b1;
    cyc(1);
    sreq <= 1'b0;
    cyc(3);
    att[1] <= 1'b1;
    cyc(1);
    att[1] <= 1'b0;
    watch(); chk(1'b0, seen);
    chk(ST_SUSPEND, bst);
    $display("test resume done");
    stop_test();
  end
endmodule : rh_hub_status_tb
